// ### hspc_consts.svh
`ifndef HSPC_CONSTS_SVH
`define HSPC_CONSTS_SVH

// Counter width and extreme values
`define HSPC_CNT_W        16
`define HSPC_CNT_MAX      16'h7fff
`define HSPC_CNT_MIN      16'h8000
`define HSPC_CNT_NEG_ONE  16'hffff
`define HSPC_CNT_ZERO     16'h0000
`define HSPC_CNT_ONE      16'h0001

// Clock and timing figures
`define HSPC_CLK_HZ       20000000
`define HSPC_MAX_RATE_HZ  10000
`define HSPC_FAST_DLY_NS  20000
`define HSPC_CLK_NS       50
// Longest terminal-to-bit delay in cycles, rounded down
`define HSPC_FAST_DLY_CYC (`HSPC_FAST_DLY_NS / `HSPC_CLK_NS)
// Shortest input half-period in cycles at the top count rate
`define HSPC_HALF_PER_CYC (`HSPC_CLK_HZ / (2 * `HSPC_MAX_RATE_HZ))

`endif

// ### hspc_counter.sv
// Function
// - Each low-to-high step of the count terminal adds one, at rates up to 10 kHz.
// - The count is a 16-bit two's complement value that only goes up.
// - A count edge at +32767 wraps the count to -32768.
// - A high load request at program cycle end loads the preset value word into the count.
// - A load request held over several program cycles reloads at each cycle end and counts in between.
// - The count value word shows the live count at all times.
// - The zero-crossing flag sets when the count steps from -1 to 0.
// - Loading the preset clears the zero-crossing flag.
// - The fast input bit follows the count terminal within 20 us.
// - Counting goes on from the loaded value until disabled or reloaded.
// - Counting runs on its own, apart from loading and reading.
// - Start values down to -32768 are accepted, giving up to 32768 pulses to zero.
// - A start value of one gives 65535 pulses before the flag sets.
`timescale 1ns/1ps
`include "hspc_consts.svh"
module hspc_counter #(
  parameter int CNT_W = `HSPC_CNT_W
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Pulse terminal
  input  wire logic             count_pin_i,
  // Program side
  input  wire logic             count_enable_i,
  input  wire logic             load_request_i,
  input  wire logic             cycle_end_i,
  input  wire logic [CNT_W-1:0] preset_value_word_i,
  // Status
  output logic [CNT_W-1:0]      count_value_word_o,
  output logic                  zero_cross_o,
  output logic                  fast_input_o,
  output logic                  load_done_o
);
  localparam logic [CNT_W-1:0] NEG_ONE = CNT_W'(`HSPC_CNT_NEG_ONE);
  localparam logic [CNT_W-1:0] ONE     = CNT_W'(`HSPC_CNT_ONE);

  logic                     pin_sync;
  logic                     pin_rise;
  logic                     do_load;
  logic [CNT_W-1:0]         count;
  logic [CNT_W-1:0]         next_count;
  logic [CNT_W-1:0]         fast_lag;
  hspc_pkg::hspc_state_t    state;
  hspc_pkg::hspc_state_t    next_state;

  // Increment with natural wrap
  function automatic logic [CNT_W-1:0] hspc_inc(input logic [CNT_W-1:0] v);
    hspc_inc = v + ONE;
  endfunction

  // Terminal synchroniser
  hspc_sync u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (count_pin_i),
    .sync_o  (pin_sync)
  );

  // Edge detector on synchronised terminal
  hspc_edge u_edge (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .level_i (pin_sync),
    .rise_o  (pin_rise)
  );

  // Load happens at program cycle end while request is high
  assign do_load = load_request_i & cycle_end_i;

  // Control state: counting, loading, or halted when disabled
  always_comb begin
    case (state)
      hspc_pkg::HSPC_ST_COUNT: next_state = do_load ? hspc_pkg::HSPC_ST_LOAD :
                                            (count_enable_i ? hspc_pkg::HSPC_ST_COUNT : hspc_pkg::HSPC_ST_HOLD);
      hspc_pkg::HSPC_ST_LOAD:  next_state = do_load ? hspc_pkg::HSPC_ST_LOAD :
                                            (count_enable_i ? hspc_pkg::HSPC_ST_COUNT : hspc_pkg::HSPC_ST_HOLD);
      hspc_pkg::HSPC_ST_HOLD:  next_state = do_load ? hspc_pkg::HSPC_ST_LOAD :
                                            (count_enable_i ? hspc_pkg::HSPC_ST_COUNT : hspc_pkg::HSPC_ST_HOLD);
      default:                 next_state = hspc_pkg::HSPC_ST_COUNT;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= hspc_pkg::HSPC_ST_COUNT;
    end else begin
      state <= next_state;
    end
  end

  // Next count: load wins, else count an edge while enabled
  always_comb begin
    next_count = count;
    if (do_load) begin
      next_count = preset_value_word_i;
    end else if (pin_rise && count_enable_i) begin
      next_count = hspc_inc(count);
    end
  end

  // Counter register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count <= CNT_W'(`HSPC_CNT_ZERO);
    end else begin
      count <= next_count;
    end
  end

  assign count_value_word_o = count;

  // Zero-crossing flag: load clears, -1 to 0 step sets
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      zero_cross_o <= 1'b0;
    end else if (do_load) begin
      zero_cross_o <= 1'b0;
    end else if (pin_rise && count_enable_i && count == NEG_ONE) begin
      zero_cross_o <= 1'b1;
    end
  end

  // Fast input mirrors synchronised terminal, 3 cycles from pin
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fast_input_o <= 1'b0;
    end else begin
      fast_input_o <= pin_sync;
    end
  end

  // One-cycle strobe after each load
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      load_done_o <= 1'b0;
    end else begin
      load_done_o <= do_load;
    end
  end

  // Cycles the fast bit has disagreed with the synchronised terminal, for the delay check
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fast_lag <= CNT_W'(`HSPC_CNT_ZERO);
    end else if (fast_input_o != pin_sync) begin
      fast_lag <= fast_lag + ONE;
    end else begin
      fast_lag <= CNT_W'(`HSPC_CNT_ZERO);
    end
  end

  // Assertions
  property p_inc;
    @(posedge mclk_i) disable iff (rst_i)
      (pin_rise && count_enable_i && !do_load) |=> (count == $past(count) + ONE);
  endproperty
  a_inc: assert property (p_inc) else $error("count did not step on edge");

  property p_upward;
    @(posedge mclk_i) disable iff (rst_i)
      (!do_load && !pin_rise) |=> $stable(count);
  endproperty
  a_upward: assert property (p_upward) else $error("count moved without edge");

  property p_wrap;
    @(posedge mclk_i) disable iff (rst_i)
      (count == CNT_W'(`HSPC_CNT_MAX) && pin_rise && count_enable_i && !do_load)
        |=> (count == CNT_W'(`HSPC_CNT_MIN));
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at max");

  property p_load;
    @(posedge mclk_i) disable iff (rst_i)
      do_load |=> (count == $past(preset_value_word_i)) && load_done_o;
  endproperty
  a_load: assert property (p_load) else $error("preset not loaded");

  property p_reload;
    @(posedge mclk_i) disable iff (rst_i)
      (load_request_i && !cycle_end_i && !pin_rise) |=> $stable(count);
  endproperty
  a_reload: assert property (p_reload) else $error("load outside cycle end");

  property p_read;
    @(posedge mclk_i) disable iff (rst_i)
      $changed(count_value_word_o) |-> $past(do_load) || $past(pin_rise && count_enable_i) || $past(rst_i);
  endproperty
  a_read: assert property (p_read) else $error("read value not live");

  property p_zset;
    @(posedge mclk_i) disable iff (rst_i)
      (count == NEG_ONE && pin_rise && count_enable_i && !do_load)
        |=> zero_cross_o && count == CNT_W'(`HSPC_CNT_ZERO);
  endproperty
  a_zset: assert property (p_zset) else $error("zero crossing not flagged");

  property p_zclr;
    @(posedge mclk_i) disable iff (rst_i)
      do_load |=> !zero_cross_o;
  endproperty
  a_zclr: assert property (p_zclr) else $error("flag not cleared by load");

  property p_fast;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(pin_sync) |=> fast_input_o;
  endproperty
  a_fast: assert property (p_fast) else $error("fast input lags");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (!count_enable_i && !do_load) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  // Control state tracks load and enable
  property p_state_onehot;
    @(posedge mclk_i) disable iff (rst_i)
      $onehot(state);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("control state not one-hot");

  property p_state_load;
    @(posedge mclk_i) disable iff (rst_i)
      do_load |=> (state == hspc_pkg::HSPC_ST_LOAD);
  endproperty
  a_state_load: assert property (p_state_load) else $error("no load state after load");

  property p_state_count;
    @(posedge mclk_i) disable iff (rst_i)
      (count_enable_i && !do_load) |=> (state == hspc_pkg::HSPC_ST_COUNT);
  endproperty
  a_state_count: assert property (p_state_count) else $error("not counting while enabled");

  property p_state_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (!count_enable_i && !do_load) |=> (state == hspc_pkg::HSPC_ST_HOLD);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("not holding while disabled");

  // Edges while disabled and lone cycle ends change nothing
  property p_disabled_edge;
    @(posedge mclk_i) disable iff (rst_i)
      (pin_rise && !count_enable_i && !do_load) |=> $stable(count) && $stable(zero_cross_o);
  endproperty
  a_disabled_edge: assert property (p_disabled_edge) else $error("count moved on disabled edge");

  property p_lone_end;
    @(posedge mclk_i) disable iff (rst_i)
      (cycle_end_i && !load_request_i && !pin_rise) |=> $stable(count);
  endproperty
  a_lone_end: assert property (p_lone_end) else $error("cycle end without request moved count");

  property p_done;
    @(posedge mclk_i) disable iff (rst_i)
      load_done_o |-> $past(do_load);
  endproperty
  a_done: assert property (p_done) else $error("load strobe without load");

  // Extreme start values
  property p_min_start;
    @(posedge mclk_i) disable iff (rst_i)
      (do_load && preset_value_word_i == CNT_W'(`HSPC_CNT_MIN)) |=> (count == CNT_W'(`HSPC_CNT_MIN));
  endproperty
  a_min_start: assert property (p_min_start) else $error("most negative start refused");

  property p_one_start;
    @(posedge mclk_i) disable iff (rst_i)
      (do_load && preset_value_word_i == ONE) |=> (count == ONE) && !zero_cross_o;
  endproperty
  a_one_start: assert property (p_one_start) else $error("start value one not taken");

  // Zero-crossing flag is sticky and moves only on its own events
  property p_zkeep;
    @(posedge mclk_i) disable iff (rst_i)
      (zero_cross_o && !do_load) |=> zero_cross_o;
  endproperty
  a_zkeep: assert property (p_zkeep) else $error("flag dropped without load");

  property p_zrise;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(zero_cross_o) |-> (count == CNT_W'(`HSPC_CNT_ZERO)) && ($past(count) == NEG_ONE);
  endproperty
  a_zrise: assert property (p_zrise) else $error("flag set off the zero crossing");

  property p_zfall;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(zero_cross_o) |-> $past(do_load) || $past(rst_i);
  endproperty
  a_zfall: assert property (p_zfall) else $error("flag cleared without load");

  // Synchroniser delay and fast-bit lag
  property p_sync;
    @(posedge mclk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(rst_i, 2)) |-> (pin_sync == $past(count_pin_i, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser delay wrong");

  property p_fast_lag;
    @(posedge mclk_i) disable iff (rst_i)
      fast_lag < CNT_W'(`HSPC_FAST_DLY_CYC);
  endproperty
  a_fast_lag: assert property (p_fast_lag) else $error("fast bit lag too long");
endmodule

// ### hspc_edge.sv
`timescale 1ns/1ps
// Rising-edge detector on a synchronised level
module hspc_edge (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Level in, pulse out
  input  wire logic level_i,
  output logic      rise_o
);
  logic prev;

  // Remember last level
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
endmodule

// ### hspc_pkg.sv
package hspc_pkg;
  // Counter control states
  typedef enum logic [2:0] {
    HSPC_ST_COUNT = 3'b001,
    HSPC_ST_LOAD  = 3'b010,
    HSPC_ST_HOLD  = 3'b100
  } hspc_state_t;
endpackage

// ### hspc_pulse_src.sv
`timescale 1ns/1ps
// Behavioural pulse source that stands on the far side of the count terminal
module hspc_pulse_src (
  // Clock
  input  wire logic        mclk_i,
  // Burst request from the bench
  input  wire logic        start_i,
  input  wire logic [15:0] num_i,
  input  wire logic [7:0]  half_i,
  // Terminal and status
  output logic             pin_o,
  output logic             busy_o
);
  // One burst of equal high and low halves, changed just after an edge; idle low between bursts
  always begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    @(posedge mclk_i iff start_i);
    #1 busy_o = 1'b1;
    repeat (num_i) begin
      pin_o = 1'b1;
      repeat (half_i) @(posedge mclk_i);
      #1 pin_o = 1'b0;
      repeat (half_i) @(posedge mclk_i);
      #1;
    end
  end
endmodule

// ### hspc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one asynchronous level
module hspc_sync (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Level in and out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;

  // Only the second stage reads the first
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  // Design inputs and partner controls
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        count_enable_i = 1'b0;
  logic        load_request_i = 1'b0;
  logic        cycle_end_i = 1'b0;
  logic [15:0] preset_value_word_i = 16'h0000;
  logic        start = 1'b0;
  logic [15:0] num = 16'h0000;
  logic        count_pin_i;
  logic        busy;
  // Design outputs
  logic [15:0] count_value_word_o;
  logic        zero_cross_o;
  logic        fast_input_o;
  logic        load_done_o;
  int          err_total = 0;
  int          check_count = 0;
  int          lag = 0;
  int          max_lag = 0;

  always #25 mclk_i = ~mclk_i;

  hspc_counter #(.CNT_W(16)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .count_pin_i(count_pin_i), .count_enable_i(count_enable_i),
    .load_request_i(load_request_i), .cycle_end_i(cycle_end_i), .preset_value_word_i(preset_value_word_i),
    .count_value_word_o(count_value_word_o), .zero_cross_o(zero_cross_o), .fast_input_o(fast_input_o),
    .load_done_o(load_done_o));

  hspc_pulse_src u_src (
    .mclk_i(mclk_i), .start_i(start), .num_i(num), .half_i(8'h06), .pin_o(count_pin_i), .busy_o(busy));

  // Longest run of cycles where the fast bit disagrees with the terminal
  always @(negedge mclk_i) begin
    lag = (count_pin_i !== fast_input_o) ? lag + 1 : 0;
    if (!rst_i && lag > max_lag) max_lag = lag;
  end

  task finish_test;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  // Program-cycle end with a load request; keep leaves the request high
  task load(input logic [15:0] p, input logic keep);
    @(negedge mclk_i);
    load_request_i = 1'b1;
    cycle_end_i = 1'b1;
    preset_value_word_i = p;
    @(negedge mclk_i);
    cycle_end_i = 1'b0;
    load_request_i = keep;
    chk_word("load count", p, count_value_word_o);
    chk_bit("load flag", 1'b0, zero_cross_o);
    chk_bit("load done", 1'b1, load_done_o);
    @(negedge mclk_i);
    chk_bit("load done end", 1'b0, load_done_o);
  endtask

  // Burst of k pulses, then time for the synchroniser to settle
  task pulses(input logic [15:0] k);
    int i;
    @(negedge mclk_i);
    num = k;
    start = 1'b1;
    @(negedge mclk_i);
    start = 1'b0;
    for (i = 0; i < 5000 && busy; i++) @(negedge mclk_i);
    if (busy) begin
      err_total++;
      finish_test;
    end else begin
      repeat (6) @(negedge mclk_i);
    end
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    chk_word("reset count", 16'h0000, count_value_word_o);
    chk_bit("reset flag", 1'b0, zero_cross_o);
    count_enable_i = 1'b1;
    load(16'hfffd, 1'b0);
    pulses(16'h0002);
    chk_word("count", 16'hffff, count_value_word_o);
    chk_bit("flag early", 1'b0, zero_cross_o);
    pulses(16'h0001);
    chk_word("count", 16'h0000, count_value_word_o);
    chk_bit("flag set", 1'b1, zero_cross_o);
    pulses(16'h0001);
    chk_bit("flag sticky", 1'b1, zero_cross_o);
    load(16'h7ffe, 1'b0);
    pulses(16'h0002);
    chk_word("wrap", 16'h8000, count_value_word_o);
    chk_bit("wrap flag", 1'b0, zero_cross_o);
    count_enable_i = 1'b0;
    pulses(16'h0003);
    chk_word("hold", 16'h8000, count_value_word_o);
    count_enable_i = 1'b1;
    load(16'h8000, 1'b0);
    pulses(16'h0001);
    chk_word("from min", 16'h8001, count_value_word_o);
    load(16'h0001, 1'b0);
    pulses(16'h0001);
    chk_word("from one", 16'h0002, count_value_word_o);
    chk_bit("from one flag", 1'b0, zero_cross_o);
    load(16'h0005, 1'b1);
    pulses(16'h0002);
    chk_word("held request", 16'h0007, count_value_word_o);
    load(16'h0005, 1'b0);
    @(negedge mclk_i);
    cycle_end_i = 1'b1;
    @(negedge mclk_i);
    cycle_end_i = 1'b0;
    chk_word("end without request", 16'h0005, count_value_word_o);
    load(16'h7fff - (16'h9c40 - 16'h8000), 1'b0);
    chk_word("long start", 16'h63bf, count_value_word_o);
    chk_bit("fast lag", 1'b1, max_lag <= 4);
    finish_test;
  end
endmodule
